// file: pci_power_state_wake_control_bench.sv
// self-checking bench for the power-state and wake control block
`timescale 1ns/1ps
`include "pm_wake_cfg.svh"

module pci_power_state_wake_control_bench;
    logic        clock_i, rst_b_i;         // 50 mhz clock, async reset
    logic        cfg_wr, cfg_rd, cfg_rv, io_wr, io_rd, io_rv;
    logic [7:0]  cfg_ofs, draw, ex;        // offset, draw, expected draw
    logic [15:0] cfg_wd, cfg_rq, io_wd, io_rq, q;
    logic [2:0]  io_win, src;              // src: pattern, magic, link
    logic [3:0]  io_ofs;
    logic        ee_v, lvr, blk_io, blk_bm, pme_out, pme_oe, pme_w;
    logic [4:0]  ee_st;                    // eeprom wake states
    int          num_errors, checks;
    logic [7:0]  draw_tbl [4] = '{8'h11, 8'h22, 8'h33, 8'h44};

    pm_wake_ctrl #(.DRAW_D0(8'h11), .DRAW_D1(8'h22), .DRAW_D2(8'h33),
                   .DRAW_D3(8'h44)) DUT
    (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_offset_i(cfg_ofs),
        .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_wdata_i(cfg_wd),
        .cfg_rdata_o(cfg_rq), .cfg_rvalid_o(cfg_rv), .io_window_i(io_win),
        .io_offset_i(io_ofs), .io_wr_i(io_wr), .io_rd_i(io_rd),
        .io_wdata_i(io_wd), .io_rdata_o(io_rq), .io_rvalid_o(io_rv),
        .eeprom_valid_i(ee_v), .eeprom_wake_states_i(ee_st),
        .low_voltage_reset_i(lvr), .pattern_frame_seen_i(src[0]),
        .magic_frame_seen_i(src[1]), .link_change_seen_i(src[2]),
        .io_mem_block_o(blk_io), .bus_master_block_o(blk_bm),
        .power_draw_data_o(draw), .pme_n_out_o(pme_out), .pme_n_oe_o(pme_oe)
    );
    pm_host_model host
    (
        .clock_i(clock_i), .cfg_ofs_o(cfg_ofs), .cfg_wr_o(cfg_wr),
        .cfg_rd_o(cfg_rd), .cfg_wd_o(cfg_wd), .cfg_rq_i(cfg_rq),
        .cfg_rv_i(cfg_rv), .io_win_o(io_win), .io_ofs_o(io_ofs),
        .io_wr_o(io_wr), .io_rd_o(io_rd), .io_wd_o(io_wd), .io_rq_i(io_rq),
        .io_rv_i(io_rv), .pme_out_i(pme_out), .pme_oe_i(pme_oe),
        .pme_w_o(pme_w)
    );

    ////////////////////////////////////////////////////////////////////
    // compare helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cw(input logic [7:0] o, input logic [15:0] d);
        host.cfg_xfer(1'b1, o, d, q);
    endtask : cw
    task automatic cr(input logic [7:0] o, input logic [15:0] e);
        host.cfg_xfer(1'b0, o, 16'h0000, q);
        chk(q, e);
    endtask : cr
    task automatic iw(input logic [15:0] d);
        host.io_xfer(1'b1, `EVT_WINDOW, `EVT_OFFSET, d, q);
    endtask : iw
    task automatic ir(input logic [15:0] e);
        host.io_xfer(1'b0, `EVT_WINDOW, `EVT_OFFSET, 16'h0000, q);
        chk(q, e);
    endtask : ir
    // one-cycle source pulses
    task automatic fire(input logic [2:0] s);
        @(negedge clock_i);
        src = s;
        @(negedge clock_i);
        src = 3'b000;
    endtask : fire
    // wake wire level, a cycle of slack for the registered pin
    task automatic pin(input logic e);
        @(negedge clock_i);
        chk({15'h0000, pme_w}, {15'h0000, e});
    endtask : pin
    task automatic ee_load(input logic [4:0] s, input logic [15:0] e);
        ee_st = s;
        @(negedge clock_i);
        ee_v = 1'b1;
        @(negedge clock_i);
        ee_v = 1'b0;
        cr(`PM_CAP_OFS, e);
    endtask : ee_load

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        cr(`PM_CAP_OFS, `PM_CAP_RESET);
        cr(`PM_CTRL_OFS, 16'h4000);
        ir(16'h0000);
        host.io_xfer(1'b0, 3'h6, `EVT_OFFSET, 16'h0000, q);
        chk(q, 16'hffff);
        ee_load(5'h1f, 16'hfe01);
        cw(`PM_CAP_OFS, 16'h0000);
        cr(`PM_CAP_OFS, 16'hfe01);
        ee_load(5'h0f, 16'h7e01);
        $display("test reset done");
    endtask : t_reset

    // every level; asleep the event register is out of reach
    task automatic t_level;
        for (int l = 0; l < 4; l++)
        begin
            cw(`PM_CTRL_OFS, 16'h00fc | 16'(l));
            cr(`PM_CTRL_OFS, 16'h4000 | 16'(l));
            chk({15'h0000, blk_io}, 16'(l != 0));
            chk({15'h0000, blk_bm}, 16'(l != 0));
            ir(l == 0 ? 16'h0000 : 16'hffff);
            iw(16'h0007);
            iw(16'h0000);
        end
        cw(`PM_CTRL_OFS, 16'h0000);
        ir(16'h0000);
        $display("test level done");
    endtask : t_level

    // all sixteen selector codes
    task automatic t_select;
        for (int s = 0; s < 16; s++)
        begin
            cw(`PM_CTRL_OFS, 16'(s) << 9);
            cr(`PM_CTRL_OFS, (16'(s) << 9) | 16'h4000);
            ex = s < 8 ? draw_tbl[s % 4] : 8'h00;
            cr(`PM_DATA_OFS, {8'h00, ex});
            chk({8'h00, draw}, {8'h00, ex});
        end
        $display("test select done");
    endtask : t_select

    // one allow bit at a time, all sources firing
    task automatic t_wake;
        for (int i = 0; i < 3; i++)
        begin
            cw(`PM_CTRL_OFS, 16'h0100);
            iw(16'h0001 << i);
            fire(3'b111);
            pin(1'b0);
            ir((16'h0001 << i) | (16'h0010 << i));
            ir(16'h0001 << i);
            cw(`PM_CTRL_OFS, 16'h0100);
            pin(1'b0);
            cw(`PM_CTRL_OFS, 16'h8100);
            pin(1'b1);
        end
        $display("test wake done");
    endtask : t_wake

    // reporting off, asleep: status still sets, pin stays quiet
    task automatic t_gate;
        iw(16'h0002);
        cw(`PM_CTRL_OFS, 16'h0003);
        fire(3'b111);
        pin(1'b1);
        cr(`PM_CTRL_OFS, 16'hc003);
        cw(`PM_CTRL_OFS, 16'h8000);
        cr(`PM_CTRL_OFS, 16'h4000);
        ir(16'h0022);
        iw(16'h0007);
        fire(3'b100);
        @(negedge clock_i);
        lvr = 1'b1;
        @(negedge clock_i);
        lvr = 1'b0;
        ir(16'h0000);
        $display("test gate done");
    endtask : t_gate

    ////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    // free-running clock
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // watchdog, far beyond the few hundred cycles needed
    initial
    begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        close_out();
    end

    // main sequence
    initial
    begin
        num_errors = 0;
        checks = 0;
        rst_b_i = 1'b0;
        {ee_v, lvr, src, ee_st} = '0;
        repeat (20) @(posedge clock_i);
        @(negedge clock_i);
        rst_b_i = 1'b1;
        t_reset();
        t_level();
        t_select();
        t_wake();
        t_gate();
        close_out();
    end
endmodule : pci_power_state_wake_control_bench

// file: pm_host_model.sv
// host side model: config and windowed i/o cycles, pulled-up wake wire
`timescale 1ns/1ps

module pm_host_model
(
    input  wire logic        clock_i,
    output logic      [7:0]  cfg_ofs_o,
    output logic             cfg_wr_o,
    output logic             cfg_rd_o,
    output logic      [15:0] cfg_wd_o,
    input  wire logic [15:0] cfg_rq_i,
    input  wire logic        cfg_rv_i,
    output logic      [2:0]  io_win_o,
    output logic      [3:0]  io_ofs_o,
    output logic             io_wr_o,
    output logic             io_rd_o,
    output logic      [15:0] io_wd_o,
    input  wire logic [15:0] io_rq_i,
    input  wire logic        io_rv_i,
    input  wire logic        pme_out_i,
    input  wire logic        pme_oe_i,
    output logic             pme_w_o
);
    // wired wake line, pulled up when nobody pulls
    assign pme_w_o = pme_oe_i ? pme_out_i : 1'b1;

    // idle bus at time zero
    initial
    begin
        {cfg_wr_o, cfg_rd_o, io_wr_o, io_rd_o} = 4'h0;
        {cfg_ofs_o, cfg_wd_o, io_win_o, io_ofs_o, io_wd_o} = '0;
    end

    ////////////////////////////////////////////////////////////////////
    // one config cycle at any offset; all x means no answer came
    task automatic cfg_xfer(input logic wr, input logic [7:0] o,
                            input logic [15:0] d, output logic [15:0] q);
        @(negedge clock_i);
        cfg_ofs_o = o;
        cfg_wd_o  = d;
        cfg_wr_o  = wr;
        cfg_rd_o  = !wr;
        @(negedge clock_i);
        cfg_wr_o  = 1'b0;
        cfg_rd_o  = 1'b0;
        // released lines wander so stale values never help
        cfg_ofs_o = ~o;
        cfg_wd_o  = ~d;
        q = (cfg_rv_i === 1'b1) ? cfg_rq_i : 16'hxxxx;
    endtask : cfg_xfer

    // one i/o cycle; all ones means no answer came
    task automatic io_xfer(input logic wr, input logic [2:0] w,
                           input logic [3:0] o, input logic [15:0] d,
                           output logic [15:0] q);
        @(negedge clock_i);
        io_win_o = w;
        io_ofs_o = o;
        io_wd_o  = d;
        io_wr_o  = wr;
        io_rd_o  = !wr;
        @(negedge clock_i);
        io_wr_o  = 1'b0;
        io_rd_o  = 1'b0;
        io_wd_o  = ~d;
        q = (io_rv_i === 1'b1) ? io_rq_i : 16'hffff;
    endtask : io_xfer
endmodule : pm_host_model

// file: pm_wake_cfg.svh
// constants for the power-state and wake control block
`ifndef PM_WAKE_CFG_SVH
`define PM_WAKE_CFG_SVH

// configuration-space offsets, relative to the capability pointer
`define PM_CAP_OFS        8'h02
`define PM_CTRL_OFS       8'h04
`define PM_DATA_OFS       8'h06

// windowed i/o location of the wake event register
`define EVT_WINDOW        3'h7
`define EVT_OFFSET        4'hc

// reset values
`define PM_CAP_RESET      16'h7601
`define PM_CTRL_RESET     16'h0000
`define EVT_RESET         16'h0000

// capability field positions
`define CAP_STATES_HI     15
`define CAP_STATES_LO     11

// control field positions
`define CTRL_STATE_HI     1
`define CTRL_STATE_LO     0
`define CTRL_PME_EN       8
`define CTRL_SEL_HI       12
`define CTRL_SEL_LO       9
`define CTRL_SCALE_HI     14
`define CTRL_SCALE_LO     13
`define CTRL_PME_STAT     15

// consumption multiplier always reads this code (0.01 watt steps)
`define SCALE_CODE        2'b10

// event register field positions
`define EVT_EN_HI         2
`define EVT_EN_LO         0
`define EVT_SEEN_HI       6
`define EVT_SEEN_LO       4

`endif

// file: pm_wake_ctrl.sv
// power-state control, capability and wake reporting top
//
// Contract
// - top capability bit reports wake from unpowered D3
// - wake-capable states loaded from eeprom after reset
// - control register 16 bits, resets to zero
// - two-bit field selects and reports sleep level
// - nonzero level blocks i/o, memory, bus master
// - control enable bit allows wake reporting on pin
// - selector picks consumption value, 8-15 unsupported
// - multiplier field always reads binary 10
// - wake status sets regardless of reporting enable
// - write one clears wake status, zero ignored
// - event register cleared by low-voltage reset
// - all source allows gated by reporting enable; the code applies allows without it, and the enable gates only the pin
// - seen flag masked by its own allow bit
// - any event register read in D0 clears seen flags
// - bit 0 allows pattern-frame wake
// - bit 1 allows magic-frame wake
// - bit 2 allows link-change wake
// - bit 4 flags pattern frame seen
// - bit 5 flags magic frame seen
// - bit 6 flags link change seen
`timescale 1ns/1ps
`include "pm_wake_cfg.svh"

module pm_wake_ctrl
#(
    parameter logic [7:0] DRAW_D0 = 8'h00, // consumption in D0
    parameter logic [7:0] DRAW_D1 = 8'h00, // consumption in D1
    parameter logic [7:0] DRAW_D2 = 8'h00, // consumption in D2
    parameter logic [7:0] DRAW_D3 = 8'h00  // consumption in D3
)
(
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // configuration-space access, offset from capability pointer
    input  wire logic [7:0]  cfg_offset_i,
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [15:0] cfg_wdata_i,
    output logic      [15:0] cfg_rdata_o,
    output logic             cfg_rvalid_o,
    // windowed i/o access
    input  wire logic [2:0]  io_window_i,
    input  wire logic [3:0]  io_offset_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [15:0] io_wdata_i,
    output logic      [15:0] io_rdata_o,
    output logic             io_rvalid_o,
    // eeprom load of the wake-capable states field
    input  wire logic        eeprom_valid_i,
    input  wire logic [4:0]  eeprom_wake_states_i,
    // low-voltage reset pulse
    input  wire logic        low_voltage_reset_i,
    // wake sources from the receive side
    input  wire logic        pattern_frame_seen_i,
    input  wire logic        magic_frame_seen_i,
    input  wire logic        link_change_seen_i,
    // blocking towards the rest of the adapter
    output logic             io_mem_block_o,
    output logic             bus_master_block_o,
    // power data value selected by the control register
    output logic      [7:0]  power_draw_data_o,
    // open-drain wake pin, active low
    output logic             pme_n_out_o,
    output logic             pme_n_oe_o
);

    ////////////////////////////////////////////////////////////////////
    // functions

    // consumption value for a selector code; unsupported gives zero
    function automatic logic [7:0] draw_lookup
    (
        input logic [3:0] sel
    );
        logic [7:0] val;
        val = 8'h00;
        if (!sel[3])
        begin
            case (sel[1:0])
                2'h0:    val = DRAW_D0;
                2'h1:    val = DRAW_D1;
                2'h2:    val = DRAW_D2;
                2'h3:    val = DRAW_D3;
                default: val = 8'h00;
            endcase
        end
        return val;
    endfunction : draw_lookup

    ////////////////////////////////////////////////////////////////////
    // declarations

    pm_wake_pkg::sleep_level_t level_q;   // current sleep level
    pm_wake_pkg::sleep_level_t level_d;
    logic        report_q;                // wake_report_allow
    logic        report_d;
    logic [3:0]  selector_q;              // consumption_selector
    logic [3:0]  selector_d;
    logic        occurred_q;              // wake_occurred_flag
    logic        occurred_d;
    logic [4:0]  states_q;                // wake_capable_states
    logic [4:0]  states_d;
    logic [15:0] cfg_rdata_q;             // config read data
    logic [15:0] cfg_rdata_d;
    logic        cfg_rvalid_q;
    logic        cfg_rvalid_d;
    logic [15:0] io_rdata_q;              // i/o read data
    logic [15:0] io_rdata_d;
    logic        io_rvalid_q;
    logic        io_rvalid_d;
    logic [7:0]  draw_q;                  // power_draw_data
    logic [7:0]  draw_d;
    logic        pme_q;                   // wake pin drive
    logic        pme_d;
    logic        awake;                   // level is D0
    logic        io_hit;                  // accepted i/o decode
    logic        cap_sel;                 // config decodes
    logic        ctrl_sel;
    logic        data_sel;
    logic [15:0] cap_image;               // capability read image
    logic [15:0] ctrl_image;              // control read image

    pm_wake_if evt ();                    // link to the event unit

    ////////////////////////////////////////////////////////////////////
    // decode

    // nonzero level: i/o cycles are ignored entirely
    assign awake    = (level_q == pm_wake_pkg::LEVEL_D0);
    assign io_hit   = awake
                    && (io_window_i == `EVT_WINDOW)
                    && (io_offset_i == `EVT_OFFSET);
    assign cap_sel  = (cfg_offset_i == `PM_CAP_OFS);
    assign ctrl_sel = (cfg_offset_i == `PM_CTRL_OFS);
    assign data_sel = (cfg_offset_i == `PM_DATA_OFS);

    // capability: version and support bits fixed, states loaded
    always_comb
    begin
        cap_image = `PM_CAP_RESET;
        // bit 15 is the unpowered-D3 wake ability
        cap_image[`CAP_STATES_HI:`CAP_STATES_LO] = states_q;
    end

    // control image; bits 7:2 read zero, multiplier is constant
    always_comb
    begin
        ctrl_image = 16'h0000;
        ctrl_image[`CTRL_STATE_HI:`CTRL_STATE_LO] = level_q;
        ctrl_image[`CTRL_PME_EN] = report_q;
        ctrl_image[`CTRL_SEL_HI:`CTRL_SEL_LO] = selector_q;
        ctrl_image[`CTRL_SCALE_HI:`CTRL_SCALE_LO] = `SCALE_CODE;
        ctrl_image[`CTRL_PME_STAT] = occurred_q;
    end

    ////////////////////////////////////////////////////////////////////
    // event unit hookup

    assign evt.io_wr      = io_wr_i && io_hit;
    assign evt.io_rd      = io_rd_i && io_hit;
    assign evt.io_wdata   = io_wdata_i;
    assign evt.lv_clear   = low_voltage_reset_i;
    assign evt.seen_pulse = {link_change_seen_i,
                             magic_frame_seen_i,
                             pattern_frame_seen_i};

    wake_event_unit u_event
    (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .bus     (evt.unit)
    );

    ////////////////////////////////////////////////////////////////////
    // control and capability next state
    always_comb
    begin
        level_d    = level_q;
        report_d   = report_q;
        selector_d = selector_q;
        occurred_d = occurred_q;
        states_d   = states_q;
        // field comes from eeprom, not a fixed value
        if (eeprom_valid_i)
        begin
            states_d = eeprom_wake_states_i;
        end
        // control register writes always land, whatever the level
        if (cfg_wr_i && ctrl_sel)
        begin
            level_d  = pm_wake_pkg::sleep_level_t'(
                cfg_wdata_i[`CTRL_STATE_HI:`CTRL_STATE_LO]);
            report_d = cfg_wdata_i[`CTRL_PME_EN];
            // all 16 codes stored; 8-15 just report zero data
            selector_d = cfg_wdata_i[`CTRL_SEL_HI:`CTRL_SEL_LO];
            // write one clears, write zero leaves it alone
            if (cfg_wdata_i[`CTRL_PME_STAT])
            begin
                occurred_d = 1'b0;
            end
        end
        // a wake in the clearing cycle wins over the clear
        if (evt.wake_hit)
        begin
            occurred_d = 1'b1;
        end
    end

    // control and capability registers
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            level_q    <= pm_wake_pkg::LEVEL_D0;
            report_q   <= 1'b0;
            selector_q <= 4'h0;
            occurred_q <= 1'b0;
            states_q   <= 5'(`PM_CAP_RESET >> `CAP_STATES_LO);
        end
        else
        begin
            level_q    <= level_d;
            report_q   <= report_d;
            selector_q <= selector_d;
            occurred_q <= occurred_d;
            states_q   <= states_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, power data and wake pin next state
    always_comb
    begin
        cfg_rdata_d  = cfg_rdata_q;
        cfg_rvalid_d = cfg_rd_i;
        io_rdata_d   = io_rdata_q;
        io_rvalid_d  = io_rd_i && io_hit;
        // reads show the value before any same-cycle update
        if (cfg_rd_i)
        begin
            if (cap_sel)
            begin
                cfg_rdata_d = cap_image;
            end
            else if (ctrl_sel)
            begin
                cfg_rdata_d = ctrl_image;
            end
            else if (data_sel)
            begin
                cfg_rdata_d = {8'h00, draw_q};
            end
            else
            begin
                // unmapped offsets read as zero
                cfg_rdata_d = 16'h0000;
            end
        end
        // ignored while asleep: no data, no valid
        if (io_rd_i && io_hit)
        begin
            io_rdata_d = evt.io_rdata;
        end
        draw_d = draw_lookup(selector_d);
        // pin only when reporting allowed; held until cleared
        pme_d  = report_d && occurred_d;
    end

    // read data, power data and wake pin registers
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cfg_rdata_q  <= 16'h0000;
            cfg_rvalid_q <= 1'b0;
            io_rdata_q   <= 16'h0000;
            io_rvalid_q  <= 1'b0;
            draw_q       <= 8'h00;
            pme_q        <= 1'b0;
        end
        else
        begin
            cfg_rdata_q  <= cfg_rdata_d;
            cfg_rvalid_q <= cfg_rvalid_d;
            io_rdata_q   <= io_rdata_d;
            io_rvalid_q  <= io_rvalid_d;
            draw_q       <= draw_d;
            pme_q        <= pme_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign cfg_rdata_o        = cfg_rdata_q;
    assign cfg_rvalid_o       = cfg_rvalid_q;
    assign io_rdata_o         = io_rdata_q;
    assign io_rvalid_o        = io_rvalid_q;
    assign power_draw_data_o  = draw_q;
    // any sleep level stops target and master traffic
    assign io_mem_block_o     = !awake;
    assign bus_master_block_o = !awake;
    // open drain: only ever pulls low
    assign pme_n_out_o        = 1'b0;
    assign pme_n_oe_o         = pme_q;

endmodule : pm_wake_ctrl

// file: pm_wake_ctrl_asserts.sv
// port-level checks for the power-state and wake control top
`timescale 1ns/1ps
`include "pm_wake_cfg.svh"

module pm_wake_ctrl_asserts
(
    input wire logic        clock_i,
    input wire logic        rst_b_i,
    input wire logic [7:0]  cfg_offset_i,
    input wire logic        cfg_wr_i,
    input wire logic        cfg_rd_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic [15:0] cfg_rdata_o,
    input wire logic        cfg_rvalid_o,
    input wire logic [2:0]  io_window_i,
    input wire logic [3:0]  io_offset_i,
    input wire logic        io_rd_i,
    input wire logic [15:0] io_rdata_o,
    input wire logic        io_rvalid_o,
    input wire logic        eeprom_valid_i,
    input wire logic [4:0]  eeprom_wake_states_i,
    input wire logic        low_voltage_reset_i,
    input wire logic        pattern_frame_seen_i,
    input wire logic        magic_frame_seen_i,
    input wire logic        link_change_seen_i,
    input wire logic        io_mem_block_o,
    input wire logic        bus_master_block_o,
    input wire logic        pme_n_out_o,
    input wire logic        pme_n_oe_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////////////
    // accepted event read, control write, any source pulse
    wire logic io_hit = io_rd_i && io_window_i == `EVT_WINDOW
                        && io_offset_i == `EVT_OFFSET && !io_mem_block_o;
    wire logic ctl_wr = cfg_wr_i && cfg_offset_i == `PM_CTRL_OFS;
    wire logic src_any = pattern_frame_seen_i | magic_frame_seen_i
                         | link_change_seen_i;

    // two quiet reads: the second must find the seen flags gone
    sequence reread_s;
        io_hit && !src_any ##1 !src_any ##1 io_hit;
    endsequence
    // low-voltage pulse, then a read
    sequence lv_read_s;
        low_voltage_reset_i ##1 !low_voltage_reset_i && !src_any ##1 io_hit;
    endsequence
    // eeprom load, then a capability read
    sequence load_read_s;
        eeprom_valid_i ##1 !eeprom_valid_i
            ##1 (cfg_rd_i && cfg_offset_i == `PM_CAP_OFS);
    endsequence

    ////////////////////////////////////////////////////////////////////
    cfg_answer_a: assert property (cfg_rd_i |=> cfg_rvalid_o)
        else $error("config read not answered");
    ctrl_scale_a: assert property (cfg_rd_i
        && cfg_offset_i == `PM_CTRL_OFS |=> cfg_rdata_o[14:13] == `SCALE_CODE)
        else $error("multiplier field wrong");
    level_block_a: assert property (ctl_wr
        && cfg_wdata_i[1:0] != 2'b00 |=> io_mem_block_o && bus_master_block_o)
        else $error("sleep level does not block");
    level_open_a: assert property (ctl_wr && cfg_wdata_i[1:0] == '0
        |=> !io_mem_block_o && !bus_master_block_o)
        else $error("full power still blocks");
    io_refuse_a: assert property (io_rd_i && io_mem_block_o
        |=> !io_rvalid_o) else $error("i/o answered while asleep");
    read_clear_a: assert property (reread_s
        |=> io_rvalid_o && io_rdata_o[`EVT_SEEN_HI:`EVT_SEEN_LO] == 3'b000)
        else $error("seen flags survive a read");
    lv_clear_a: assert property (lv_read_s
        |=> io_rdata_o == 16'h0000) else $error("event reg not cleared");
    cap_load_a: assert property (load_read_s
        |=> cfg_rdata_o[15:11] == $past(eeprom_wake_states_i, 3))
        else $error("wake states not loaded");
    pin_drop_a: assert property (ctl_wr && !cfg_wdata_i[8]
        |-> ##[1:2] !pme_n_oe_o)
        else $error("wake pin driven while disallowed");
    pin_hold_a: assert property (pme_n_oe_o && !ctl_wr
        && !$past(ctl_wr) |=> pme_n_oe_o && !pme_n_out_o)
        else $error("wake pin released early");
endmodule : pm_wake_ctrl_asserts

bind pm_wake_ctrl pm_wake_ctrl_asserts chk_u
(
    .clock_i, .rst_b_i, .cfg_offset_i, .cfg_wr_i, .cfg_rd_i, .cfg_wdata_i,
    .cfg_rdata_o, .cfg_rvalid_o, .io_window_i, .io_offset_i, .io_rd_i,
    .io_rdata_o, .io_rvalid_o, .eeprom_valid_i, .eeprom_wake_states_i,
    .low_voltage_reset_i, .pattern_frame_seen_i, .magic_frame_seen_i,
    .link_change_seen_i, .io_mem_block_o, .bus_master_block_o,
    .pme_n_out_o, .pme_n_oe_o
);

// file: pm_wake_if.sv
// carrier between the control top and the wake event unit
`timescale 1ns/1ps

interface pm_wake_if;
    logic                   io_wr;      // accepted write to event reg
    logic                   io_rd;      // accepted read of event reg
    logic [15:0]            io_wdata;   // write data
    logic [15:0]            io_rdata;   // current event reg image
    pm_wake_pkg::wake_src_t seen_pulse; // raw source pulses
    logic                   lv_clear;   // low-voltage reset pulse
    logic                   wake_hit;   // an enabled source fired

    modport ctl
    (
        output io_wr, io_rd, io_wdata, seen_pulse, lv_clear,
        input  io_rdata, wake_hit
    );

    modport unit
    (
        input  io_wr, io_rd, io_wdata, seen_pulse, lv_clear,
        output io_rdata, wake_hit
    );
endinterface : pm_wake_if

// file: pm_wake_pkg.sv
// types shared by the power-state and wake control block
package pm_wake_pkg;

    // device sleep levels held in the control register
    typedef enum logic [1:0]
    {
        LEVEL_D0,
        LEVEL_D1,
        LEVEL_D2,
        LEVEL_D3
    } sleep_level_t;

    // one bit per wake source: pattern, magic, link
    typedef logic [2:0] wake_src_t;

endpackage : pm_wake_pkg

// file: wake_event_unit.sv
// wake event register: per-source enables and sticky seen flags
`timescale 1ns/1ps
`include "pm_wake_cfg.svh"

module wake_event_unit
(
    input  wire logic   clock_i,
    input  wire logic   rst_b_i,
    pm_wake_if.unit     bus
);

    pm_wake_pkg::wake_src_t allow_q;   // pattern/magic/link allows
    pm_wake_pkg::wake_src_t allow_d;
    pm_wake_pkg::wake_src_t seen_q;    // sticky seen flags
    pm_wake_pkg::wake_src_t seen_d;
    pm_wake_pkg::wake_src_t hit;       // masked source pulses

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        // a source only counts when its own allow bit is set
        hit     = bus.seen_pulse & allow_q;
        allow_d = allow_q;
        seen_d  = seen_q;
        if (bus.lv_clear)
        begin
            // low-voltage reset wipes the whole register
            allow_d = '0;
            seen_d  = '0;
        end
        else
        begin
            if (bus.io_wr)
            begin
                // bit 0 pattern, bit 1 magic, bit 2 link
                allow_d = bus.io_wdata[`EVT_EN_HI:`EVT_EN_LO];
            end
            // read clears, but a new hit in the same cycle survives
            if (bus.io_rd)
            begin
                seen_d = '0;
            end
            seen_d = seen_d | hit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            allow_q <= '0;
            seen_q  <= '0;
        end
        else
        begin
            allow_q <= allow_d;
            seen_q  <= seen_d;
        end
    end

    // register image; bit 3 and bits 15:7 read as zero
    assign bus.io_rdata = {9'h0_00, seen_q, 1'b0, allow_q};
    assign bus.wake_hit = |hit;

endmodule : wake_event_unit
